// ==== pkg/ocef_consts.svh ====
// Purpose: Constants for the output compare error flag block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
`ifndef OCEF_CONSTS_SVH
`define OCEF_CONSTS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define OCEF_OFF_FLAGS 12'h000
`define OCEF_OFF_IRQ_EN 12'h004
`define OCEF_OFF_FORCE 12'h008
`define OCEF_ADDR_W 12

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define OCEF_NCHK 12
`define OCEF_EXT_TOP 31
`define OCEF_BAS_TOP 19
`define OCEF_FIELD_LO 8
`define OCEF_RESV_MASK 32'hFFFF_FF00
`define OCEF_RESET_VAL 32'h0000_0000
`define OCEF_ZERO_WORD 32'h0000_0000
`define OCEF_ZERO_ADDR 12'h000

`endif

// ==== pkg/ocef_pkg.sv ====
// Purpose: Types for the output compare error flag block
// Assumes: Constants come from ocef_consts.svh
// Notes: Packed state of the top module
`include "ocef_consts.svh"
package ocef_pkg;
  typedef enum logic [1:0] {
    OCEF_IDLE = 2'b00,
    OCEF_ACCESS = 2'b01
  } ocef_phase_t;

  typedef struct packed {
    ocef_phase_t phase;
    logic [31:0] flags;
    logic [31:0] irq_en;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic normal_interrupt_line;
    logic checker_error_output;
  } ocef_state_t;
endpackage

// ==== rtl/ocef_pair_checker.sv ====
// Purpose: Bitwise pair checkers for one timer group
// Assumes: Timer output bits already synchronised to pclk
// Notes: Checker n compares bits 2n and 2n+1, gated by its enable
`timescale 1ns/1ps
`default_nettype none
`include "ocef_consts.svh"
module ocef_pair_checker
  import ocef_pkg::*;
(
  input wire logic [2*`OCEF_NCHK-1:0] timer_bits,
  input wire logic [`OCEF_NCHK-1:0] check_enable,
  output logic [`OCEF_NCHK-1:0] mismatch
);
  // ----------------------------------------------------------------
  // Anti-valence per pair
  // ----------------------------------------------------------------
  genvar n;
  generate
    for (n = 0; n < `OCEF_NCHK; n = n + 1) begin : g_pair
      assign mismatch[n] = check_enable[n] &
                           (timer_bits[2*n] ^ timer_bits[2*n+1]);
    end
  endgenerate
endmodule
`default_nettype wire

// ==== rtl/ocef_top.sv ====
// Purpose: Sticky comparator error flags with interrupt enables on APB
// Assumes: Timer outputs arrive from other timing and are synchronised
// Notes: Set wins over a simultaneous clear
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ocef_consts.svh"
module ocef_top
  import ocef_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`OCEF_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2*`OCEF_NCHK-1:0] extended_output_timers,
  input wire logic [2*`OCEF_NCHK-1:0] basic_output_timers,
  input wire logic [`OCEF_NCHK-1:0] extended_check_enable,
  input wire logic [`OCEF_NCHK-1:0] basic_check_enable,
  output logic normal_interrupt_line,
  output logic checker_error_output
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [2*`OCEF_NCHK-1:0] ext_meta_reg;
  logic [2*`OCEF_NCHK-1:0] ext_sync_reg;
  logic [2*`OCEF_NCHK-1:0] bas_meta_reg;
  logic [2*`OCEF_NCHK-1:0] bas_sync_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_meta_reg <= '0;
      ext_sync_reg <= '0;
      bas_meta_reg <= '0;
      bas_sync_reg <= '0;
    end else begin
      ext_meta_reg <= extended_output_timers;
      ext_sync_reg <= ext_meta_reg;
      bas_meta_reg <= basic_output_timers;
      bas_sync_reg <= bas_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Pair checkers
  // ----------------------------------------------------------------
  logic [`OCEF_NCHK-1:0] ext_mismatch;
  logic [`OCEF_NCHK-1:0] bas_mismatch;

  ocef_pair_checker u_ext (
    .timer_bits(ext_sync_reg),
    .check_enable(extended_check_enable),
    .mismatch(ext_mismatch)
  );

  ocef_pair_checker u_bas (
    .timer_bits(bas_sync_reg),
    .check_enable(basic_check_enable),
    .mismatch(bas_mismatch)
  );

  // ----------------------------------------------------------------
  // Map checkers onto register bits
  // ----------------------------------------------------------------
  logic [31:0] hw_set;
  genvar n;
  generate
    for (n = 0; n < 32; n = n + 1) begin : g_map
      if (n > `OCEF_BAS_TOP) begin : g_ext
        assign hw_set[n] = ext_mismatch[`OCEF_EXT_TOP-n];
      end else if (n >= `OCEF_FIELD_LO) begin : g_bas
        assign hw_set[n] = bas_mismatch[`OCEF_BAS_TOP-n];
      end else begin : g_resv
        assign hw_set[n] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ocef_state_t state_reg;
  ocef_state_t state_next;
  logic [31:0] wmask;
  logic [31:0] wdata;
  logic wr_take;
  logic rd_take;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;

  always_comb begin
    state_next = state_reg;
    wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    wdata = pwdata & wmask & `OCEF_RESV_MASK;
    wr_take = 1'b0;
    rd_take = 1'b0;
    set_vec = hw_set;
    clr_vec = `OCEF_ZERO_WORD;
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;
    case (state_reg.phase)
      OCEF_IDLE: begin
        if (psel && !penable) begin
          state_next.phase = OCEF_ACCESS;
        end
      end
      OCEF_ACCESS: begin
        // Answer in the second access cycle
        if (psel && penable && !state_reg.pready) begin
          state_next.pready = 1'b1;
          wr_take = pwrite;
          rd_take = !pwrite;
          state_next.phase = OCEF_IDLE;
        end else if (!psel) begin
          state_next.phase = OCEF_IDLE;
        end
      end
      default: begin
        state_next.phase = OCEF_IDLE;
      end
    endcase
    if (wr_take) begin
      case (paddr)
        `OCEF_OFF_FLAGS: begin
          clr_vec = wdata;
        end
        `OCEF_OFF_IRQ_EN: begin
          state_next.irq_en = (state_reg.irq_en & ~wmask) | wdata;
        end
        `OCEF_OFF_FORCE: begin
          set_vec = set_vec | wdata;
        end
        default: begin
          state_next.pslverr = 1'b1;
        end
      endcase
    end
    state_next.flags = ((state_reg.flags & ~clr_vec) | set_vec)
                       & `OCEF_RESV_MASK;
    if (rd_take) begin
      // side-effect free read, low byte zero
      case (paddr)
        `OCEF_OFF_FLAGS: state_next.prdata = state_reg.flags;
        `OCEF_OFF_IRQ_EN: state_next.prdata = state_reg.irq_en;
        `OCEF_OFF_FORCE: state_next.prdata = `OCEF_ZERO_WORD;
        default: begin
          state_next.prdata = `OCEF_ZERO_WORD;
          state_next.pslverr = 1'b1;
        end
      endcase
    end
    state_next.normal_interrupt_line =
      |(state_next.flags & state_next.irq_en);
    state_next.checker_error_output = |state_next.flags;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.phase <= OCEF_IDLE;
      state_reg.flags <= `OCEF_RESET_VAL;
      state_reg.irq_en <= `OCEF_RESET_VAL;
      state_reg.prdata <= `OCEF_ZERO_WORD;
      state_reg.pready <= 1'b0;
      state_reg.pslverr <= 1'b0;
      state_reg.normal_interrupt_line <= 1'b0;
      state_reg.checker_error_output <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign normal_interrupt_line = state_reg.normal_interrupt_line;
  assign checker_error_output = state_reg.checker_error_output;
endmodule
`default_nettype wire

// ==== verification/ocef_timer_model.sv ====
// Purpose: Timer output pairs seen by the pair checkers
// Assumes: mis bit k upsets pair k; basic pairs from k=12
// Notes: Both bits of a pair toggle together every cycle
`timescale 1ns/1ps
`default_nettype none
module ocef_timer_model (
  input wire logic pclk,
  input wire logic [23:0] mis,
  output logic [23:0] ext_bits,
  output logic [23:0] bas_bits
);
  logic ph = 1'b0;
  always @(posedge pclk) ph <= ~ph;
  always_comb begin
    for (int n = 0; n < 12; n++) begin
      ext_bits[2*n] = ph;
      ext_bits[2*n+1] = ph ^ mis[n];
      bas_bits[2*n] = ph;
      bas_bits[2*n+1] = ph ^ mis[n+12];
    end
  end
endmodule
`default_nettype wire

// ==== verification/ocef_top_monitor.sv ====
// Purpose: Port checks for the error flag block
// Assumes: One wait state per transfer
// Notes: Bound to every ocef_top
`timescale 1ns/1ps
`default_nettype none
module ocef_top_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic normal_interrupt_line,
  input wire logic checker_error_output
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------
  // Bus and outputs
  // ----------------
  chk_ready_bound: assert property (psel && penable |-> ##[0:2] pready)
    else $error("ready missing");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  chk_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  chk_resv_zero: assert property (
    pready && !pwrite |-> prdata[7:0] == 8'h00) else $error("low bits");
  chk_unmap_zero: assert property (
    pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped data");
  chk_irq_needs_err: assert property (
    normal_interrupt_line |-> checker_error_output)
    else $error("irq without error");
  chk_read_keeps: assert property (
    pready && !pwrite |=> !$fell(checker_error_output))
    else $error("read cleared");
  chk_err_fall: assert property ($fell(checker_error_output) |->
    pready && pwrite)
    else $error("error fell alone");
  cover property (pready && pslverr);
  cover property ($rose(normal_interrupt_line));
  cover property ($rose(checker_error_output));
endmodule
bind ocef_top ocef_top_monitor u_ocef_top_monitor (.pclk, .presetn,
  .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .normal_interrupt_line, .checker_error_output);
`default_nettype wire

// ==== verification/tb_top.sv ====
// Purpose: Register level bench for the error flag block
// Assumes: Flags 0x000, enables 0x004, force 0x008
// Notes: Pair k maps to flag bit 31-k
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, irq, err, serr;
  logic [11:0] paddr = 12'h000, en = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat, exp;
  logic [23:0] mis = 24'h0, ext_t, bas_t;
  int errors = 0, n_checks = 0;
  ocef_timer_model u_ocef_timer_model (.pclk(pclk), .mis(mis),
    .ext_bits(ext_t), .bas_bits(bas_t));
  ocef_top u_ocef_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extended_output_timers(ext_t), .basic_output_timers(bas_t),
    .extended_check_enable(en), .basic_check_enable(en),
    .normal_interrupt_line(irq), .checker_error_output(err));
  initial forever #12.5 pclk = ~pclk;
  // ----------------
  // Bus and checks
  // ----------------
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata; serr = pslverr; psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic compare(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    errors++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 12'h000, 0); compare(rdat, 32'h0);
    apb(0, 12'h004, 0); compare(rdat, 32'h0);
    mis <= 24'h00_0001;
    repeat (8) @(posedge pclk);
    mis <= 24'h0;
    apb(0, 12'h000, 0); compare(rdat, 32'h0);
    en <= 12'hFFF;
    apb(1, 12'h004, 32'hFFFF_FF00);
    apb(0, 12'h004, 0); compare(rdat, 32'hFFFF_FF00);
    for (int k = 0; k < 24; k++) begin
      exp = 32'h1 << (31 - k);
      mis <= 24'h00_0001 << k;
      repeat (4) @(posedge pclk);
      mis <= 24'h0;
      repeat (4) @(posedge pclk);
      apb(0, 12'h000, 0); compare(rdat, exp);
      apb(0, 12'h000, 0); compare(rdat, exp);
      compare({irq, err}, 32'h3);
      apb(1, 12'h000, ~exp & 32'hFFFF_FF00);
      apb(0, 12'h000, 0); compare(rdat, exp);
      apb(1, 12'h000, exp);
      apb(0, 12'h000, 0); compare(rdat, 32'h0);
      compare({irq, err}, 32'h0);
    end
    mis <= 24'h00_0001;
    repeat (4) @(posedge pclk);
    apb(1, 12'h000, 32'h8000_0000);
    apb(0, 12'h000, 0); compare(rdat, 32'h8000_0000);
    mis <= 24'h0;
    repeat (4) @(posedge pclk);
    apb(1, 12'h000, 32'h8000_0000);
    apb(0, 12'h000, 0); compare(rdat, 32'h0);
    apb(1, 12'h004, 32'h0);
    apb(1, 12'h008, 32'h0008_0000);
    repeat (3) @(posedge pclk);
    apb(0, 12'h000, 0); compare(rdat, 32'h0008_0000);
    apb(0, 12'h008, 0); compare(rdat, 32'h0);
    compare({irq, err}, 32'h1);
    apb(1, 12'h004, 32'h0008_0000);
    repeat (3) @(posedge pclk);
    compare({irq, err}, 32'h3);
    apb(0, 12'h00C, 0); compare(rdat, 32'h0);
    compare({31'h0, serr}, 32'h1);
    end_sim();
  end
endmodule
`default_nettype wire
